// ### shared/spi_readback_pkg.sv
package spi_readback_pkg;
    // Frame field layout: bit 7 output select / watchdog toggle, 6:4 address, 3:0 data
    localparam int FRAME_BITS = 8;
    localparam int CNT_W = 3;
    localparam int BIT_SEL = 7;
    localparam int ADDR_MSB = 6;
    localparam int ADDR_LSB = 4;
    localparam int DATA_MSB = 3;
    localparam int SEL_MSB = 2;

    localparam logic [2:0] ADDR_STATUS_SEL = 3'h0;
    localparam logic [2:0] ADDR_OUT_CTRL = 3'h1;
    localparam logic [2:0] ADDR_CUR_LIMIT = 3'h2;
    localparam logic [2:0] ADDR_BLANK_OL = 3'h3;
    localparam logic [2:0] ADDR_DIRECT_IN = 3'h4;
    localparam logic [2:0] ADDR_DELAY_WD = 3'h5;
    localparam logic [2:0] ADDR_NOACT_SUPPLY = 3'h6;

    localparam logic [2:0] SEL_FAULT = 3'h0;
    localparam logic [2:0] SEL_OUT_CTRL = 3'h1;
    localparam logic [2:0] SEL_CUR_LIMIT = 3'h2;
    localparam logic [2:0] SEL_BLANK_OL = 3'h3;
    localparam logic [2:0] SEL_DIRECT_IN = 3'h4;
    localparam logic [2:0] SEL_DELAY_WD = 3'h5;
    localparam logic [2:0] SEL_PINS_SUPPLY = 3'h6;
    localparam logic [2:0] SEL_NULL = 3'h7;

    // Output control nibble: sense1, soft1, sense0, soft0
    localparam int SOFT_ZERO_POS = 0;
    localparam int SOFT_ONE_POS = 2;

    localparam logic [2:0] SEL_RESET = 3'h7;
    localparam logic [3:0] NIBBLE_RESET = 4'h0;
    localparam logic [2:0] DELAY_RESET = 3'h0;
    localparam logic [1:0] PAIR_RESET = 2'h0;

    typedef struct packed {
        logic overtemp_flag;
        logic overcurrent_high_flag;
        logic overcurrent_low_flag;
        logic open_load_flag;
    } out_faults_t;

    typedef struct packed {
        out_faults_t [1:0] out;
        logic undervoltage_flag;
        logic overvoltage_flag;
        logic watchdog_expired;
        logic failsafe_state_one;
        logic failsafe_state_zero;
    } fault_inputs_t;
endpackage

// ### core/spi_status_readback.sv
`timescale 1ns/1ps
module spi_status_readback #(
    parameter logic NULL_BIT3 = 1'b0
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic si_i,
    output logic so_o,
    output logic so_oe_o,
    input wire spi_readback_pkg::fault_inputs_t fault_i,
    input wire logic direct_input_zero_i,
    input wire logic direct_input_one_i,
    input wire logic failsafe_input_pin_i,
    input wire logic wake_i,
    output logic fault_out_pin_n_o
);
    // Link side: SI sampled on falling edge, SO launched on rising edge
    logic [7:0] rx_sh_reg;
    logic [spi_readback_pkg::CNT_W-1:0] bit_cnt_reg;
    logic byte_seen_reg;
    logic frame_open_reg;
    logic frame_tgl_reg;
    logic so_reg;
    logic so_oe_reg;
    logic [7:0] status_word_reg;
    logic [7:0] rx_base;

    assign rx_base = frame_open_reg ? rx_sh_reg : status_word_reg;

    // Shift data and count are kept after the frame so the core clock can read them
    always_ff @(negedge sclk_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            frame_open_reg <= 1'b0;
        end else begin
            frame_open_reg <= 1'b1;
        end
    end

    always_ff @(negedge sclk_i) begin
        if (!cs_n_i) begin
            rx_sh_reg <= {rx_base[6:0], si_i};
            bit_cnt_reg <= frame_open_reg ? bit_cnt_reg + 1'b1 : 3'h1;
            byte_seen_reg <= frame_open_reg & (byte_seen_reg | (bit_cnt_reg == 3'h7));
            if (!frame_open_reg) begin
                frame_tgl_reg <= ~frame_tgl_reg;
            end
        end
    end

    always_ff @(posedge sclk_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            so_reg <= 1'b0;
            so_oe_reg <= 1'b0;
        end else begin
            so_reg <= frame_open_reg ? rx_sh_reg[7] : status_word_reg[7];
            so_oe_reg <= 1'b1;
        end
    end

    assign so_o = so_reg;
    assign so_oe_o = so_oe_reg;

    // Core clock side: synchronisers
    logic cs_meta_reg, cs_sync_reg, cs_prev_reg;
    logic tgl_meta_reg, tgl_sync_reg, tgl_seen_reg;
    logic [3:0] pin_meta_reg, pin_sync_reg;
    logic [1:0] din_prev_reg;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            cs_meta_reg <= 1'b1;
            cs_sync_reg <= 1'b1;
            cs_prev_reg <= 1'b1;
            tgl_meta_reg <= 1'b0;
            tgl_sync_reg <= 1'b0;
            tgl_seen_reg <= 1'b0;
            pin_meta_reg <= 4'h0;
            pin_sync_reg <= 4'h0;
            din_prev_reg <= 2'h0;
        end else if (ce_i) begin
            cs_meta_reg <= cs_n_i;
            cs_sync_reg <= cs_meta_reg;
            cs_prev_reg <= cs_sync_reg;
            tgl_meta_reg <= frame_tgl_reg;
            tgl_sync_reg <= tgl_meta_reg;
            tgl_seen_reg <= cs_sync_reg ? tgl_sync_reg : tgl_seen_reg;
            pin_meta_reg <= {direct_input_one_i, direct_input_zero_i, failsafe_input_pin_i, wake_i};
            pin_sync_reg <= pin_meta_reg;
            din_prev_reg <= pin_sync_reg[3:2];
        end
    end

    // Frame end decode; shift data is quiet because the link clock stops with chip select high
    logic frame_end, frame_ok, idle;
    logic [2:0] wr_addr;
    logic wr_out;
    logic [3:0] wr_data;

    assign idle = cs_sync_reg & cs_prev_reg;
    assign frame_end = cs_sync_reg & ~cs_prev_reg & (tgl_sync_reg != tgl_seen_reg);
    assign frame_ok = frame_end & (bit_cnt_reg == 3'h0) & byte_seen_reg;
    assign wr_addr = rx_sh_reg[spi_readback_pkg::ADDR_MSB:spi_readback_pkg::ADDR_LSB];
    assign wr_out = rx_sh_reg[spi_readback_pkg::BIT_SEL];
    assign wr_data = rx_sh_reg[spi_readback_pkg::DATA_MSB:0];

    logic [2:0] status_select_reg;
    logic prev_d7_reg;
    logic [3:0] out_ctrl_reg;
    logic [3:0] current_limit_reg [2];
    logic [3:0] blanking_openload_reg [2];
    logic [3:0] direct_input_cfg_reg [2];
    logic [2:0] switch_delay_reg;
    logic [1:0] watchdog_period_reg;
    logic [1:0] supply_protect_reg;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            status_select_reg <= spi_readback_pkg::SEL_RESET;
            prev_d7_reg <= 1'b0;
            out_ctrl_reg <= spi_readback_pkg::NIBBLE_RESET;
            switch_delay_reg <= spi_readback_pkg::DELAY_RESET;
            watchdog_period_reg <= spi_readback_pkg::PAIR_RESET;
            supply_protect_reg <= spi_readback_pkg::PAIR_RESET;
        end else if (ce_i && frame_ok) begin
            prev_d7_reg <= wr_out;
            if (wr_addr == spi_readback_pkg::ADDR_STATUS_SEL) begin
                status_select_reg <= wr_data[spi_readback_pkg::SEL_MSB:0];
            end
            if (wr_addr == spi_readback_pkg::ADDR_OUT_CTRL) begin
                out_ctrl_reg <= wr_data;
            end
            if (wr_addr == spi_readback_pkg::ADDR_DELAY_WD && !wr_out) begin
                switch_delay_reg <= wr_data[2:0];
            end
            if (wr_addr == spi_readback_pkg::ADDR_DELAY_WD && wr_out) begin
                watchdog_period_reg <= wr_data[1:0];
            end
            if (wr_addr == spi_readback_pkg::ADDR_NOACT_SUPPLY && wr_out) begin
                supply_protect_reg <= wr_data[1:0];
            end
        end
    end

    // Per-output configuration and latched over-current flags
    logic [1:0] ochf_lat_reg, oclf_lat_reg, switch_on;
    logic [1:0] soft_rise;

    for (genvar o = 0; o < 2; o++) begin : g_out
        localparam int SOFT_POS = (o == 0) ? spi_readback_pkg::SOFT_ZERO_POS : spi_readback_pkg::SOFT_ONE_POS;
        logic hit;
        assign hit = frame_ok & (wr_out == 1'(o));
        assign soft_rise[o] = frame_ok & (wr_addr == spi_readback_pkg::ADDR_OUT_CTRL)
                              & wr_data[SOFT_POS] & ~out_ctrl_reg[SOFT_POS];
        assign switch_on[o] = soft_rise[o] | (pin_sync_reg[2 + o] & ~din_prev_reg[o]);

        always_ff @(posedge clk_i) begin
            if (srst_i) begin
                current_limit_reg[o] <= spi_readback_pkg::NIBBLE_RESET;
                blanking_openload_reg[o] <= spi_readback_pkg::NIBBLE_RESET;
                direct_input_cfg_reg[o] <= spi_readback_pkg::NIBBLE_RESET;
                ochf_lat_reg[o] <= 1'b0;
                oclf_lat_reg[o] <= 1'b0;
            end else if (ce_i) begin
                if (hit && wr_addr == spi_readback_pkg::ADDR_CUR_LIMIT) begin
                    current_limit_reg[o] <= wr_data;
                end
                if (hit && wr_addr == spi_readback_pkg::ADDR_BLANK_OL) begin
                    blanking_openload_reg[o] <= wr_data;
                end
                if (hit && wr_addr == spi_readback_pkg::ADDR_DIRECT_IN) begin
                    direct_input_cfg_reg[o] <= wr_data;
                end
                // New fault wins over a switch-on in the same cycle
                ochf_lat_reg[o] <= fault_i.out[o].overcurrent_high_flag
                                   | (ochf_lat_reg[o] & ~switch_on[o]);
                oclf_lat_reg[o] <= fault_i.out[o].overcurrent_low_flag
                                   | (oclf_lat_reg[o] & ~switch_on[o]);
            end
        end
    end

    // Fault summary, cleared by a valid frame that returned the fault view
    logic fault_any, summary_reg, fault_out_n_reg, read_clear;
    logic [2:0] cap_sel_reg;

    assign fault_any = (|ochf_lat_reg) | (|oclf_lat_reg) | fault_i.undervoltage_flag | fault_i.overvoltage_flag
                       | fault_i.out[0].overtemp_flag | fault_i.out[1].overtemp_flag
                       | fault_i.out[0].open_load_flag | fault_i.out[1].open_load_flag;
    assign read_clear = frame_ok & (cap_sel_reg == spi_readback_pkg::SEL_FAULT);

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            summary_reg <= 1'b0;
            fault_out_n_reg <= 1'b1;
            cap_sel_reg <= spi_readback_pkg::SEL_RESET;
        end else if (ce_i) begin
            summary_reg <= fault_any | (summary_reg & ~read_clear);
            fault_out_n_reg <= ~fault_any;
            cap_sel_reg <= idle ? status_select_reg : cap_sel_reg;
        end
    end

    assign fault_out_pin_n_o = fault_out_n_reg;

    // Readback word; bit 7 always the prior valid frame's output select
    logic [3:0] view_low;
    logic [7:0] word_next;
    logic ps;
    spi_readback_pkg::out_faults_t fo;

    assign ps = prev_d7_reg;
    assign fo = fault_i.out[ps];

    always_comb begin
        view_low = 4'h0;
        unique case (status_select_reg)
            spi_readback_pkg::SEL_FAULT: view_low = 4'h0;
            spi_readback_pkg::SEL_OUT_CTRL: view_low = out_ctrl_reg;
            spi_readback_pkg::SEL_CUR_LIMIT: view_low = current_limit_reg[ps];
            spi_readback_pkg::SEL_BLANK_OL: view_low = blanking_openload_reg[ps];
            spi_readback_pkg::SEL_DIRECT_IN: view_low = direct_input_cfg_reg[ps];
            spi_readback_pkg::SEL_DELAY_WD: view_low = ps ? {fault_i.failsafe_state_one, fault_i.watchdog_expired,
                                                             watchdog_period_reg}
                                                          : {fault_i.failsafe_state_zero, switch_delay_reg};
            spi_readback_pkg::SEL_PINS_SUPPLY: view_low = ps ? {2'h0, supply_protect_reg}
                                                             : pin_sync_reg;
            spi_readback_pkg::SEL_NULL: view_low = {NULL_BIT3, 3'h0};
        endcase
    end

    assign word_next = (status_select_reg == spi_readback_pkg::SEL_FAULT)
        ? {ps, fo.overtemp_flag, ochf_lat_reg[ps], oclf_lat_reg[ps], fo.open_load_flag,
           fault_i.undervoltage_flag, fault_i.overvoltage_flag, summary_reg}
        : (status_select_reg == spi_readback_pkg::SEL_NULL) ? {ps, 3'h0, view_low}
        : {ps, status_select_reg, view_low};

    // Frozen while a frame runs so the link samples a steady word; limitation:
    // a chip select fall within two core cycles of a frame end may see the old word
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            status_word_reg <= {1'b0, 3'h0, NULL_BIT3, 3'h0};
        end else if (ce_i && idle) begin
            status_word_reg <= word_next;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i || !ce_i);

    sequence idle_s;
        cs_sync_reg && cs_prev_reg;
    endsequence

    sequence bad_frame_s;
        frame_end && !frame_ok;
    endsequence

    sel_hold_a: assert property (!(frame_ok && wr_addr == spi_readback_pkg::ADDR_STATUS_SEL)
        |=> status_select_reg == $past(status_select_reg))
        else $error("selector changed without a status-select write");
    bad_frame_a: assert property (bad_frame_s |=> $stable(prev_d7_reg) && $stable(status_select_reg))
        else $error("invalid frame altered state");
    word_frozen_a: assert property (!cs_sync_reg |=> $stable(status_word_reg))
        else $error("status word moved during a frame");
    bit_seven_a: assert property (idle_s ##1 idle_s |-> status_word_reg[7] == $past(prev_d7_reg))
        else $error("bit 7 does not return prior select bit");
    summary_set_a: assert property (fault_any |=> summary_reg)
        else $error("summary bit missed a fault");
    oc_latch_a: assert property (ochf_lat_reg[0] && !switch_on[0] |=> ochf_lat_reg[0])
        else $error("over-current flag released without switch-on");
    fault_pin_a: assert property (fault_any |=> !fault_out_pin_n_o)
        else $error("fault pin not asserted");
    null_view_a: assert property (idle_s and (status_select_reg == spi_readback_pkg::SEL_NULL)
        |=> status_word_reg[2:0] == 3'h0)
        else $error("null view low bits not zero");
    sel_echo_a: assert property (idle_s and (status_select_reg inside {[3'h1:3'h6]})
        |=> status_word_reg[6:4] == $past(status_select_reg))
        else $error("selector echo wrong");
    so_release_a: assert property (@(posedge clk_i) disable iff (srst_i)
        cs_n_i |-> !so_oe_o)
        else $error("serial output driven with chip select high");
endmodule

// ### testbench/spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model (
    output logic sclk_o,
    output logic cs_n_o,
    output logic si_o,
    input wire logic so_i,
    input wire logic so_oe_i
);
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        si_o = 1'b0;
    end

    // Clock idles low and only toggles inside a frame; 6 ns per bit
    task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx, output logic oe_ok);
        rx = 16'h0000;
        oe_ok = 1'b1;
        cs_n_o = 1'b0;
        #20;
        for (int i = n - 1; i >= 0; i--) begin
            si_o = tx[i];
            #1.5;
            sclk_o = 1'b1;
            #3;
            rx = {rx[14:0], so_i};
            oe_ok = oe_ok & so_oe_i;
            sclk_o = 1'b0;
            #1.5;
        end
        #10;
        cs_n_o = 1'b1;
        // Undriven line must not look like a held bit
        si_o = ~si_o;
    endtask
endmodule

// ### testbench/spi_status_readback_bench.sv
`timescale 1ns/1ps
module spi_status_readback_bench;
    logic clk_i;
    logic srst_i;
    logic sclk;
    logic cs_n;
    logic si;
    logic so;
    logic so_oe;
    spi_readback_pkg::fault_inputs_t fault;
    logic in_zero;
    logic in_one;
    logic fs_pin;
    logic wake;
    logic fault_pin_n;
    int fail_count;
    int samples_checked;
    int cycles;
    logic [15:0] rx;
    logic oe_ok;
    // Config command, then expected readback byte
    logic [15:0] cfg_table [8] = '{16'h1A1A, 16'hA9A9, 16'h3636, 16'hC5C5,
                                   16'h555D, 16'hD2D6, 16'hE3E3, 16'h606A};

    spi_status_readback dut (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .ce_i(1'b1),
        .sclk_i(sclk),
        .cs_n_i(cs_n),
        .si_i(si),
        .so_o(so),
        .so_oe_o(so_oe),
        .fault_i(fault),
        .direct_input_zero_i(in_zero),
        .direct_input_one_i(in_one),
        .failsafe_input_pin_i(fs_pin),
        .wake_i(wake),
        .fault_out_pin_n_o(fault_pin_n)
    );

    spi_host_model host (
        .sclk_o(sclk),
        .cs_n_o(cs_n),
        .si_o(si),
        .so_i(so),
        .so_oe_i(so_oe)
    );

    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    task results;
        $display("checks %0d errors %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 6000) begin
            $display("ERROR timeout expected done seen hang");
            fail_count++;
            results();
        end
    end

    task check(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Leaves cs_n high long enough for the core to evaluate the frame
    task frame(input logic [15:0] tx, input int n);
        @(negedge clk_i);
        host.xfer(tx, n, rx, oe_ok);
        repeat (8) @(negedge clk_i);
    endtask

    task wr(input logic [7:0] cmd);
        frame({8'h00, cmd}, 8);
    endtask

    task rd(input logic [7:0] cmd, input logic [7:0] exp, input string what);
        frame({8'hC5, cmd}, 16);
        check(what, exp, rx[15:8]);
        check("echo", 8'hC5, rx[7:0]);
        check("output enable", 8'h01, {7'h00, oe_ok});
        check("idle output", 8'h00, {6'h00, so_oe, so});
    endtask

    initial begin
        srst_i = 1'b1;
        fault = '0;
        in_zero = 1'b0;
        in_one = 1'b0;
        fs_pin = 1'b1;
        wake = 1'b0;
        fail_count = 0;
        samples_checked = 0;
        cycles = 0;
        repeat (6) @(negedge clk_i);
        srst_i = 1'b0;
        repeat (6) @(negedge clk_i);
        wr(8'h70);
        rd(8'h70, 8'h00, "null word");
        frame(16'h0080, 12);
        rd(8'h70, 8'h00, "after short frame");
        wr(8'h00);
        fault.out[0].overtemp_flag = 1'b1;
        repeat (4) @(negedge clk_i);
        fault.out[0].overtemp_flag = 1'b0;
        rd(8'h60, 8'h01, "summary held");
        rd(8'h60, 8'h00, "summary cleared");
        fault.out[0] = 4'h9;
        fault.undervoltage_flag = 1'b1;
        fault.overvoltage_flag = 1'b1;
        repeat (4) @(negedge clk_i);
        rd(8'hF0, 8'h4F, "fault word zero");
        fault.out[0] = 4'h0;
        fault.undervoltage_flag = 1'b0;
        fault.overvoltage_flag = 1'b0;
        fault.out[1].overcurrent_high_flag = 1'b1;
        repeat (4) @(negedge clk_i);
        fault.out[1].overcurrent_high_flag = 1'b0;
        repeat (6) @(negedge clk_i);
        check("fault pin latched", 8'h00, {7'h00, fault_pin_n});
        rd(8'hF0, 8'hA1, "fault word one");
        rd(8'hF0, 8'hA1, "high flag latched");
        in_one = 1'b1;
        repeat (8) @(negedge clk_i);
        check("fault pin released", 8'h01, {7'h00, fault_pin_n});
        rd(8'hF0, 8'h81, "latch released");
        rd(8'hF0, 8'h80, "summary after release");
        fault.failsafe_state_zero = 1'b1;
        fault.watchdog_expired = 1'b1;
        foreach (cfg_table[i]) begin
            wr(cfg_table[i][15:8]);
            wr({cfg_table[i][7], 4'h0, cfg_table[i][6:4]});
            rd({cfg_table[i][7], 7'h70}, cfg_table[i][7:0], "readback");
        end
        results();
    end
endmodule
